// File: src/plc_pkg.sv
// Package for the parallel LCD / camera / converter port: map, fields, types
package plc_pkg;
  // ==========================================================================
  // Register byte offsets (APB, one aligned 32-bit word each)
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_LAYOUT = 8'h04;
  localparam logic [7:0] OFF_CLKDIV = 8'h08;
  localparam logic [7:0] OFF_TXDATA = 8'h0c;
  localparam logic [7:0] OFF_RXDATA = 8'h10;
  localparam logic [7:0] OFF_RAW    = 8'h14;
  localparam logic [7:0] OFF_CLEAR  = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  // ==========================================================================
  // Control word fields and reset values
  localparam int CTRL_W = 14;
  localparam logic [13:0] CTRL_RST   = 14'h0000;
  localparam logic [11:0] LAYOUT_RST = 12'h000;
  localparam logic [7:0]  CLKDIV_RST = 8'h04;
  localparam logic [2:0]  LAYOUT_CAM = 3'h1;
  typedef struct packed {
    logic rx_msb_shift;
    logic tx_msb_shift;
    logic rx_short_sync;
    logic tx_short_sync;
    logic rx_msb_right;
    logic rx_right_first;
    logic data_doubling;
    logic strobe_doubling;
    logic rx_start;
    logic tx_start;
    logic camera_enable;
    logic rx_follower_select;
    logic tx_follower_select;
    logic parallel_mode_enable;
  } plc_ctrl_t;
  // Layout word: four 3-bit fields
  typedef struct packed {
    logic [2:0] rx_queue_layout;
    logic [2:0] rx_channel_layout;
    logic [2:0] tx_queue_layout;
    logic [2:0] tx_channel_layout;
  } plc_layout_t;
  // ==========================================================================
  // Pins and side-band bundles
  typedef struct packed {
    logic        line_sync_in;
    logic        frame_sync_in;
    logic        line_valid_in;
    logic [15:0] pixel_data_in;
  } plc_cam_t;
  typedef struct packed {
    logic in_descr_done;
    logic in_complete;
    logic out_drained;
    logic out_packet_done;
    logic in_descriptor_error;
    logic out_descriptor_error;
    logic in_chain_empty;
    logic out_lists_done;
  } plc_dma_evt_t;
  // ==========================================================================
  // Event bit positions in the raw status word
  localparam int EV_TX_TIMEOUT = 0;
  localparam int EV_RX_TIMEOUT = 1;
  localparam int EV_TX_EMPTY   = 2;
  localparam int EV_TX_FULL    = 3;
  localparam int EV_RX_EMPTY   = 4;
  localparam int EV_RX_FULL    = 5;
  localparam int EV_TX_LOW     = 6;
  localparam int EV_RX_HIGH    = 7;
  localparam int EV_DMA_LSB    = 8;
  localparam int EV_W          = 16;
  // ==========================================================================
  // Queues and timing
  localparam int QDEPTH = 4;
  localparam int PTR_W  = 2;
  localparam logic [2:0] Q_FULL  = 3'd4;
  localparam logic [2:0] Q_LOW   = 3'd1;
  localparam logic [2:0] Q_HIGH  = 3'd3;
  localparam int CLK_MHZ = 100;
  localparam int HUNG_US = 10;
  localparam logic [10:0] HUNG_CYC = 11'(HUNG_US * CLK_MHZ);
  // Operating modes
  typedef enum logic [4:0] {
    MODE_IDLE = 5'b00001,
    MODE_LCD  = 5'b00010,
    MODE_CAM  = 5'b00100,
    MODE_ADC  = 5'b01000,
    MODE_DAC  = 5'b10000
  } plc_mode_t;
endpackage : plc_pkg

// File: src/plc_port.sv
// Parallel LCD / camera / converter port with APB registers
// ============================================================================
// Notes on behaviour
// - Word select runs at half bit clock
// - LCD: 24-bit bus, word select strobes
// - LCD when enabled and tx follower clear
// - LCD data laid out by layout fields
// - Strobe/data doubling pick frame form
// - Camera: 16-bit data, syncs, pixel clock
// - Capture only while all three high
// - Camera mode decode from five controls
// - Camera packing uses layouts equal one
// - ADC: master receive, paced by strobe
// - DAC: right to first, left second
// - DAC sample in upper element byte
// - DAC decode needs sync/shift bits clear
// - Timeout events for transmit and receive
// - Queue empty and full events
// - Low and high water events
// - Lists consumed, receive chain empty events
// - Descriptor error events, both chains
// - Packet done and drained events
// - Receive complete and descriptor done events
// - Raw status bits regardless of enables
// - Empty transmitter repeats last data
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module plc_port
  import plc_pkg::*;
(
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // Strobe / pixel clock pin
  input  wire logic                 word_select_in,
  output logic                      word_select_out,
  output logic                      word_select_oe,
  output logic                      bit_clock_out,
  // Camera pins
  input  wire plc_pkg::plc_cam_t    cam_in,
  // LCD and DAC outputs
  output logic [23:0]               lcd_data_out,
  output logic [7:0]                dac_right_out,
  output logic [7:0]                dac_left_out,
  // On-chip ADC results and DMA events
  input  wire logic [15:0]          adc_data_in,
  input  wire plc_pkg::plc_dma_evt_t dma_evt_in
);
  import plc_pkg::*;

  // ==========================================================================
  // Helpers
  // LCD word from a queue word; 16-bit modes pick one half by channel layout
  function automatic logic [23:0] lcd_word(input logic [31:0] w, input logic [2:0] chan,
                                           input logic [2:0] qmode);
    logic [15:0] half;
    half = (chan == 3'd1) ? w[31:16] : w[15:0];
    lcd_word = qmode[1] ? w[23:0] : {8'h00, half};
  endfunction : lcd_word
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = p + 1'b1;
  endfunction : ptr_inc

  // ==========================================================================
  // Registers
  plc_ctrl_t        ctrl_q;
  plc_layout_t      layout_q;
  logic [7:0]       clkdiv_q;
  logic [EV_W-1:0]  raw_q;
  logic [EV_W-1:0]  raw_d;
  logic             pready_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;
  plc_mode_t        mode_q;
  plc_mode_t        mode_d;

  // APB decode: answer one cycle into the access phase
  wire acc      = psel & penable;
  wire done     = acc & pready_q;
  wire wr_done  = done & pwrite;
  wire rd_done  = done & ~pwrite;
  wire hit      = (paddr[7:5] == 3'b000) & (paddr[1:0] == 2'b00);
  wire wr_ctrl  = wr_done & (paddr == OFF_CTRL);
  wire wr_lay   = wr_done & (paddr == OFF_LAYOUT);
  wire wr_div   = wr_done & (paddr == OFF_CLKDIV);
  wire wr_tx    = wr_done & (paddr == OFF_TXDATA);
  wire wr_clr   = wr_done & (paddr == OFF_CLEAR);
  wire rd_rx    = rd_done & (paddr == OFF_RXDATA);

  // ==========================================================================
  // Queues: four words each, software side and link side
  logic [31:0]      txq_mem [QDEPTH];
  logic [31:0]      rxq_mem [QDEPTH];
  logic [PTR_W-1:0] txq_wp_q;
  logic [PTR_W-1:0] txq_rp_q;
  logic [PTR_W-1:0] rxq_wp_q;
  logic [PTR_W-1:0] rxq_rp_q;
  logic [2:0]       txq_cnt_q;
  logic [2:0]       rxq_cnt_q;
  wire  tx_empty = (txq_cnt_q == 3'd0);
  wire  tx_full  = (txq_cnt_q == Q_FULL);
  wire  rx_empty = (rxq_cnt_q == 3'd0);
  wire  rx_full  = (rxq_cnt_q == Q_FULL);
  logic tx_pop;
  logic rx_push;
  logic [31:0] rx_word;
  // A write to a full queue is dropped rather than stalling the bus
  wire  tx_push = wr_tx & ~tx_full;
  wire  rx_pop  = rd_rx & ~rx_empty;

  // ==========================================================================
  // Mode decode
  wire  en        = ctrl_q.parallel_mode_enable;
  wire  cam_sel   = en & ctrl_q.camera_enable & ctrl_q.rx_follower_select
                  & ~ctrl_q.rx_right_first & ~ctrl_q.rx_msb_right;
  wire  dac_sel   = en & ~ctrl_q.tx_follower_select & ~ctrl_q.tx_short_sync
                  & ~ctrl_q.rx_short_sync & ~ctrl_q.tx_msb_shift
                  & ~ctrl_q.rx_msb_shift & (layout_q.tx_queue_layout == 3'd0);
  wire  lcd_sel   = en & ~ctrl_q.tx_follower_select;
  wire  adc_sel   = en & ~ctrl_q.rx_follower_select & ~ctrl_q.camera_enable;
  // Camera first, then DAC (narrower decode of transmit), LCD, ADC
  always_comb
  begin
    if (cam_sel)
      mode_d = MODE_CAM;
    else if (dac_sel && ctrl_q.tx_start)
      mode_d = MODE_DAC;
    else if (lcd_sel && ctrl_q.tx_start)
      mode_d = MODE_LCD;
    else if (adc_sel && ctrl_q.rx_start)
      mode_d = MODE_ADC;
    else
      mode_d = MODE_IDLE;
  end
  wire master_run = (mode_q == MODE_LCD) | (mode_q == MODE_DAC) | (mode_q == MODE_ADC);

  // ==========================================================================
  // Bit clock divider and word select
  logic [7:0] div_cnt_q;
  logic       bck_q;
  logic       ws_q;
  logic       ws_oe_q;
  wire        div_hit = (div_cnt_q >= clkdiv_q);
  wire        bck_rise = master_run & div_hit & ~bck_q;
  wire        ws_fall = bck_rise & ws_q;
  wire        ws_rise = bck_rise & ~ws_q;
  // Divider restarts whenever no master mode runs, so the first edge is clean
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_q <= 8'h00;
      bck_q     <= 1'b0;
      ws_q      <= 1'b0;
      ws_oe_q   <= 1'b0;
    end
    else
    begin
      div_cnt_q <= (!master_run || div_hit) ? 8'h00 : div_cnt_q + 8'h01;
      bck_q     <= master_run & (div_hit ? ~bck_q : bck_q);
      ws_q      <= master_run & (bck_rise ? ~ws_q : ws_q);
      ws_oe_q   <= master_run;
    end
  end

  // ==========================================================================
  // LCD and DAC transmit path
  logic [23:0] lcd_q;
  logic [7:0]  dac_r_q;
  logic [7:0]  dac_l_q;
  logic        half_q;
  wire  [31:0] tx_head = txq_mem[txq_rp_q];
  // Form 1 (strobe doubling only) holds each word for two strobes;
  // form 2 (both set) gives a new word on every strobe
  wire  hold_two = ctrl_q.strobe_doubling & ~ctrl_q.data_doubling;
  wire  tx_slot  = ws_fall & ((mode_q == MODE_LCD) | (mode_q == MODE_DAC))
                 & ~(hold_two & ~half_q);
  assign tx_pop  = tx_slot & ~tx_empty;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lcd_q   <= 24'h000000;
      dac_r_q <= 8'h00;
      dac_l_q <= 8'h00;
      half_q  <= 1'b0;
    end
    else
    begin
      if (ws_fall)
        half_q <= ~half_q;
      // Empty queue leaves the last word standing on the bus
      if (tx_pop && mode_q == MODE_LCD)
        lcd_q <= lcd_word(tx_head, layout_q.tx_channel_layout,
                          layout_q.tx_queue_layout);
      if (tx_pop && mode_q == MODE_DAC)
      begin
        dac_r_q <= tx_head[15:8];
        dac_l_q <= tx_head[31:24];
      end
    end
  end

  // ==========================================================================
  // Camera pins: two flip-flops before any logic looks at them
  plc_cam_t cam_s1_q;
  plc_cam_t cam_s2_q;
  logic     pclk_s1_q;
  logic     pclk_s2_q;
  logic     pclk_s3_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cam_s1_q  <= '0;
      cam_s2_q  <= '0;
      pclk_s1_q <= 1'b0;
      pclk_s2_q <= 1'b0;
      pclk_s3_q <= 1'b0;
    end
    else
    begin
      cam_s1_q  <= cam_in;
      cam_s2_q  <= cam_s1_q;
      pclk_s1_q <= word_select_in;
      pclk_s2_q <= pclk_s1_q;
      pclk_s3_q <= pclk_s2_q;
    end
  end
  wire cam_qual = cam_s2_q.line_sync_in & cam_s2_q.frame_sync_in
                & cam_s2_q.line_valid_in;
  wire cam_pack = (layout_q.rx_channel_layout == LAYOUT_CAM)
                & (layout_q.rx_queue_layout == LAYOUT_CAM);
  wire cam_take = (mode_q == MODE_CAM) & ctrl_q.rx_start & pclk_s2_q & ~pclk_s3_q
                & cam_qual & cam_pack;
  // ADC results are sampled on each rising strobe
  wire adc_take = (mode_q == MODE_ADC) & ws_rise;
  assign rx_word = {16'h0000, cam_take ? cam_s2_q.pixel_data_in : adc_data_in};
  // A full receive queue drops the word; the full event tells software
  assign rx_push = (cam_take | adc_take) & ~rx_full;

  // ==========================================================================
  // Queue storage and pointers
  always_ff @(posedge pclk)
  begin
    if (tx_push)
      txq_mem[txq_wp_q] <= pwdata;
    if (rx_push)
      rxq_mem[rxq_wp_q] <= rx_word;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txq_wp_q  <= '0;
      txq_rp_q  <= '0;
      rxq_wp_q  <= '0;
      rxq_rp_q  <= '0;
      txq_cnt_q <= 3'd0;
      rxq_cnt_q <= 3'd0;
    end
    else
    begin
      if (tx_push)
        txq_wp_q <= ptr_inc(txq_wp_q);
      if (tx_pop)
        txq_rp_q <= ptr_inc(txq_rp_q);
      if (rx_push)
        rxq_wp_q <= ptr_inc(rxq_wp_q);
      if (rx_pop)
        rxq_rp_q <= ptr_inc(rxq_rp_q);
      txq_cnt_q <= txq_cnt_q + {2'b00, tx_push} - {2'b00, tx_pop};
      rxq_cnt_q <= rxq_cnt_q + {2'b00, rx_push} - {2'b00, rx_pop};
    end
  end

  // ==========================================================================
  // Stall timers
  logic [10:0] tx_idle_q;
  logic [10:0] rx_idle_q;
  wire  tx_wait  = ((mode_q == MODE_LCD) | (mode_q == MODE_DAC)) & tx_empty;
  wire  rx_wait  = ((mode_q == MODE_CAM) | (mode_q == MODE_ADC)) & ctrl_q.rx_start
                 & ~rx_push;
  wire  tx_hung  = tx_wait & (tx_idle_q == HUNG_CYC - 11'd1);
  wire  rx_hung  = rx_wait & (rx_idle_q == HUNG_CYC - 11'd1);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_idle_q <= 11'd0;
      rx_idle_q <= 11'd0;
    end
    else
    begin
      tx_idle_q <= (tx_wait && !tx_hung) ? tx_idle_q + 11'd1 : 11'd0;
      rx_idle_q <= (rx_wait && !rx_hung) ? rx_idle_q + 11'd1 : 11'd0;
    end
  end

  // ==========================================================================
  // Raw event status: edges of queue levels, timers and DMA pulses
  logic [7:0]  lvl_prev_q;
  wire  [7:0]  lvl_now = {rxq_cnt_q >= Q_HIGH, txq_cnt_q <= Q_LOW, rx_full, rx_empty,
                          tx_full, tx_empty, 2'b00};
  wire  [EV_W-1:0] ev_set = {dma_evt_in,
                             lvl_now & ~lvl_prev_q} | {14'h0000, rx_hung, tx_hung};
  // Setting wins over a clear in the same cycle
  assign raw_d = (raw_q & ~(wr_clr ? pwdata[EV_W-1:0] : '0)) | ev_set;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      raw_q      <= '0;
      lvl_prev_q <= 8'h54;
      mode_q     <= MODE_IDLE;
    end
    else
    begin
      raw_q      <= raw_d;
      lvl_prev_q <= lvl_now;
      mode_q     <= mode_d;
    end
  end

  // ==========================================================================
  // APB register writes and read answer
  logic [31:0] rd_mux;
  always_comb
  begin
    case (paddr)
      OFF_CTRL:   rd_mux = {18'h00000, ctrl_q};
      OFF_LAYOUT: rd_mux = {20'h00000, layout_q};
      OFF_CLKDIV: rd_mux = {24'h000000, clkdiv_q};
      OFF_RXDATA: rd_mux = rxq_mem[rxq_rp_q];
      OFF_RAW:    rd_mux = {16'h0000, raw_q};
      OFF_STATUS: rd_mux = {21'h000000, rxq_cnt_q, txq_cnt_q, mode_q};
      default:    rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q    <= CTRL_RST;
      layout_q  <= LAYOUT_RST;
      clkdiv_q  <= CLKDIV_RST;
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= acc & ~pready_q;
      prdata_q  <= (acc && !pready_q && !pwrite) ? rd_mux : 32'h00000000;
      pslverr_q <= acc & ~pready_q & ~hit;
      if (wr_ctrl)
        ctrl_q <= pwdata[CTRL_W-1:0];
      if (wr_lay)
        layout_q <= pwdata[11:0];
      if (wr_div)
        clkdiv_q <= pwdata[7:0];
    end
  end

  // ==========================================================================
  // Outputs straight from flip-flops
  assign pready          = pready_q;
  assign prdata          = prdata_q;
  assign pslverr         = pslverr_q;
  assign word_select_out = ws_q;
  assign word_select_oe  = ws_oe_q;
  assign bit_clock_out   = bck_q;
  assign lcd_data_out    = lcd_q;
  assign dac_right_out   = dac_r_q;
  assign dac_left_out    = dac_l_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_bck_up;
    master_run && !bit_clock_out ##1 bit_clock_out;
  endsequence
  a_ws_on_bck: assert property ($changed(word_select_out) && $past(master_run)
    |-> $rose(bit_clock_out)) else $error("word select moved off a bit clock rise");
  a_ws_half_rate: assert property (s_bck_up |->
    word_select_out != $past(word_select_out, 1)) else $error("word select not half rate");
  a_lcd_repeat: assert property (tx_empty && mode_q == MODE_LCD |=>
    $stable(lcd_data_out)) else $error("lcd bus changed with empty queue");
  a_lcd_decode: assert property (mode_q == MODE_LCD |-> $past(lcd_sel)
    && !$past(cam_sel)) else $error("lcd mode without its controls");
  a_cam_qualify: assert property (mode_q == MODE_CAM && !(cam_s2_q.line_sync_in
    && cam_s2_q.frame_sync_in && cam_s2_q.line_valid_in) |=> $stable(rxq_wp_q)) else $error("capture unqualified");
  a_cam_decode: assert property (mode_q == MODE_CAM |-> $past(ctrl_q.parallel_mode_enable)
    && !$past(ctrl_q.rx_msb_right)) else $error("camera mode wrong decode");
  a_dac_bytes: assert property (tx_pop && mode_q == MODE_DAC |=>
    dac_right_out == $past(tx_head[15:8]) && dac_left_out == $past(tx_head[31:24]))
    else $error("dac bytes misplaced");
  a_raw_set_wins: assert property (|ev_set |=> (raw_q & $past(ev_set)) == $past(ev_set))
    else $error("event lost against clear");
  a_tx_hung: assert property (tx_wait [*8] ##0 (tx_idle_q == HUNG_CYC - 11'd1) |=>
    raw_q[EV_TX_TIMEOUT]) else $error("transmit timeout not raised");
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
endmodule : plc_port

// File: src/plc_unused_placeholder_none.sv
// Intentionally empty: all logic lives in plc_port
`timescale 1ns/1ns

// File: sim/plc_cam_model.sv
// Behavioural camera module driving pixel clock, qualifiers and pixel data
`timescale 1ns/1ns
module plc_cam_model
  import plc_pkg::*;
(
  // Bench control
  input  wire logic        start,
  input  wire logic [15:0] base,
  // Camera pins
  output logic             pix_clk,
  output plc_pkg::plc_cam_t cam,
  output logic             busy
);
  int i;
  // ==========================================================================
  // Pixel clock is still outside a frame
  initial
  begin
    pix_clk = 1'b0;
    cam = '0;
    busy = 1'b0;
  end
  // Four pixels; the second has line valid low and must not be taken
  always @(posedge start)
  begin
    busy = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      cam.line_sync_in = 1'b1;
      cam.frame_sync_in = 1'b1;
      cam.line_valid_in = (i != 1);
      cam.pixel_data_in = base + 16'(i);
      #80 pix_clk = 1'b1;
      #80 pix_clk = 1'b0;
    end
    // Released lines show the inverse of the last value, not a stale copy
    cam.line_sync_in = 1'b0;
    cam.frame_sync_in = 1'b0;
    cam.line_valid_in = 1'b0;
    cam.pixel_data_in = ~cam.pixel_data_in;
    busy = 1'b0;
  end
endmodule : plc_cam_model

// File: sim/testbench.sv
// Self-checking bench for the parallel LCD / camera / converter port
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
`define WAITFOR(c) begin n = 0; while (!(c) && n < 3000) begin @(posedge pclk); n++; end \
  if (n >= 3000) begin fail_count++; final_report(); end end
module testbench;
  import plc_pkg::*;
  // ==========================================================================
  // Signals
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]   paddr, dac_r, dac_l;
  logic [31:0]  pwdata, prdata, rd;
  logic         ws_out, ws_oe, bit_clock, pix_clk, cam_go, cam_busy, pw, pb;
  logic [23:0]  lcd;
  logic [15:0]  adc;
  plc_cam_t     cam;
  plc_dma_evt_t dma;
  int           fail_count, num_checks, n, nw, nb, k;
  always #5 pclk = ~pclk;
  plc_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .word_select_in(pix_clk), .word_select_out(ws_out),
    .word_select_oe(ws_oe), .bit_clock_out(bit_clock), .cam_in(cam), .lcd_data_out(lcd),
    .dac_right_out(dac_r), .dac_left_out(dac_l), .adc_data_in(adc), .dma_evt_in(dma));
  plc_cam_model cam_u (.start(cam_go), .base(16'h7100), .pix_clk(pix_clk), .cam(cam),
    .busy(cam_busy));
  // ==========================================================================
  // Verdict and APB master tasks
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // Setup, then access until pready; one idle cycle after, so no double drive
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && t < 50)
    begin
      @(posedge pclk);
      t++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 50)
    begin
      fail_count++;
      final_report();
    end
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdchk
  // ==========================================================================
  // Main sequence
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cam_go = 1'b0;
    adc = 16'h0a5c;
    dma = '0;
    fail_count = 0;
    num_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, unmapped and misaligned places
    rdchk(OFF_LAYOUT, 32'h0);
    rdchk(OFF_CLKDIV, {24'h0, CLKDIV_RST});
    rdchk(OFF_STATUS, {27'h0, MODE_IDLE});
    apb(1'b0, 8'h20, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, 8'h02, 32'hffff_ffff);
    `CHK(err, 1'b1)
    rdchk(OFF_CTRL, 32'h0);
    // LCD: 24-bit words, strobe on word select, last word repeated
    wr(OFF_LAYOUT, 32'h010);
    wr(OFF_TXDATA, 32'hffab_cdef);
    wr(OFF_TXDATA, 32'h0012_3456);
    wr(OFF_CTRL, 32'h11);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd[4:0], MODE_LCD)
    `CHK(ws_oe, 1'b1)
    `WAITFOR(lcd === 24'habcdef)
    `WAITFOR(lcd === 24'h123456)
    nw = 0;
    nb = 0;
    pw = ws_out;
    pb = bit_clock;
    repeat (200)
    begin
      @(posedge pclk);
      nw += int'(ws_out & ~pw);
      nb += int'(bit_clock & ~pb);
      pw = ws_out;
      pb = bit_clock;
    end
    `CHK(nb, 2 * nw)
    `CHK(nw, 200 / (4 * (int'(CLKDIV_RST) + 1)))
    `CHK(lcd, 24'h123456)
    // Starved transmitter times out after its limit
    repeat (1100) @(posedge pclk);
    apb(1'b0, OFF_RAW, 32'h0);
    `CHK({rd[EV_TX_TIMEOUT], rd[EV_TX_EMPTY], rd[EV_TX_LOW]}, 3'b111)
    // DAC: right byte from [15:8], left from [31:24]; sync bits forbid it
    wr(OFF_CTRL, 32'h0);
    wr(OFF_LAYOUT, 32'h0);
    wr(OFF_TXDATA, 32'h5a00_3c00);
    wr(OFF_CTRL, 32'h411);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd[4:0], MODE_LCD)
    wr(OFF_CTRL, 32'h11);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd[4:0], MODE_DAC)
    `WAITFOR(dac_r === 8'h3c)
    `CHK(dac_l, 8'h5a)
    // Form 1: each word stands for two strobes
    wr(OFF_CTRL, 32'h0);
    wr(OFF_LAYOUT, 32'h010);
    wr(OFF_TXDATA, 32'h0011_1111);
    wr(OFF_TXDATA, 32'h0022_2222);
    wr(OFF_CTRL, 32'h51);
    `WAITFOR(lcd === 24'h111111)
    nw = 0;
    pw = ws_out;
    n = 0;
    while (lcd !== 24'h222222 && n < 200)
    begin
      @(posedge pclk);
      n++;
      nw += int'(pw & ~ws_out);
      pw = ws_out;
    end
    `CHK(nw, 2)
    // Camera: right-first set refuses the mode, then capture when qualified
    wr(OFF_CTRL, 32'h0);
    wr(OFF_LAYOUT, 32'h240);
    wr(OFF_CTRL, 32'h12d);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd[4:0] == MODE_CAM, 1'b0)
    wr(OFF_CTRL, 32'h2d);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK({ws_oe, rd[4:0]}, {1'b0, MODE_CAM})
    cam_go <= 1'b1;
    @(posedge pclk);
    cam_go <= 1'b0;
    `WAITFOR(cam_busy === 1'b0)
    repeat (10) @(posedge pclk);
    rdchk(OFF_RXDATA, 32'h0000_7100);
    rdchk(OFF_RXDATA, 32'h0000_7102);
    rdchk(OFF_RXDATA, 32'h0000_7103);
    rdchk(OFF_STATUS, {27'h0, MODE_CAM});
    // ADC: master receive fills the queue at word select pace
    wr(OFF_CTRL, 32'h21);
    wr(OFF_CLEAR, 32'hffff);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK({ws_oe, rd[4:0]}, {1'b1, MODE_ADC})
    repeat (200) @(posedge pclk);
    apb(1'b0, OFF_RAW, 32'h0);
    `CHK({rd[EV_RX_FULL], rd[EV_RX_HIGH]}, 2'b11)
    rdchk(OFF_RXDATA, 32'h0000_0a5c);
    wr(OFF_CTRL, 32'h0);
    // DMA side events land in raw bits, read-only, cleared by write-one
    for (k = 0; k < 8; k++)
    begin
      dma <= plc_dma_evt_t'(8'h01 << k);
      @(posedge pclk);
    end
    dma <= '0;
    wr(OFF_RAW, 32'h0);
    apb(1'b0, OFF_RAW, 32'h0);
    `CHK(rd[15:8], 8'hff)
    wr(OFF_CLEAR, 32'hff00);
    apb(1'b0, OFF_RAW, 32'h0);
    `CHK(rd[15:8], 8'h00)
    final_report();
  end
endmodule : testbench
